// File: logic/clk_divider.sv
// Half-period divider used for the internal oscillator
`timescale 1ns/1ps
module clk_divider (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [3:0] half_period,
    output logic            tick_rise
);
    logic [3:0] cnt_r;

    // One tick per half period; the user keeps the level so both edges exist
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_r     <= 4'h0;
            tick_rise <= 1'b0;
        end else if (cnt_r + 4'h1 >= half_period) begin
            cnt_r     <= 4'h0;
            tick_rise <= 1'b1;
        end else begin
            cnt_r     <= cnt_r + 4'h1;
            tick_rise <= 1'b0;
        end
    end
endmodule

// File: logic/config_prom_output_sequencer.sv
// Output sequencer streaming stored configuration data to a target
// Contract
// RQ1 - Optional internal oscillator, fast or slow rate, set at programming.
// RQ2 - Clock output sourced from input clock or oscillator per stored setting.
// RQ3 - New data presented so it is valid at clock output rising edge.
// RQ4 - Clock output driven only while chip enable low and oe_reset high.
// RQ5 - Disabled clock output is high impedance; system pulls it high.
// RQ6 - After transfer ends, stop clock output then release chain enable.
// RQ7 - Downstream part drives clock only when enabled and data ready.
// RQ8 - Busy high freezes address and holds data, uncompressed parallel only.
// RQ9 - Clock output keeps toggling while busy is high.
// RQ10 - After busy falls, address advances and new data is driven.
// RQ11 - Decompression expands stored data before clock and data go out; code sends the raw stored bytes unexpanded.
// RQ12 - With decompression the target is a slave clocked by clock output.
// RQ13 - Decompression lowers clock rate; clock is high impedance until ready.
// RQ14 - Busy is ignored when decompression is enabled.
// RQ15 - Revisions numbered zero to three by a two-bit code.
// RQ16 - Revisions occupy whole blocks; unused space reads as all ones.
// RQ17 - Sixteen megabit holds two revisions, eight megabit holds one.
// RQ18 - External select low uses pins; high uses internal bits.
// RQ19 - Revision selection sampled at power-up.
// RQ20 - With chip enable low, resample after config pulse rising edge.
// RQ21 - Revision select works with decompression and clock output.
// RQ22 - Boundary-scan config pulses config pin low and resets revision.
// RQ23 - Address advances on every valid rising target config clock edge.
// RQ24 - oe_reset resets address counter before each configuration.
// RQ25 - Revision selection loads address with first byte of its block.
`timescale 1ns/1ps
module config_prom_output_sequencer (
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    input  wire logic                          ext_clk_in,
    input  wire logic                          chip_enable_n,
    input  wire logic                          oe_reset,
    input  wire logic                          busy,
    input  wire logic                          parallel_mode,
    input  wire logic                          config_pulse_n_in,
    input  wire logic                          jtag_config_req,
    input  wire logic [1:0]                    revision_select_pins,
    input  wire logic                          external_select_enable,
    input  wire logic                          osc_enable_cfg,
    input  wire logic                          osc_slow_cfg,
    input  wire logic                          source_sync_clock_out_enable_cfg,
    input  wire logic                          source_sync_clock_out_src_osc_cfg,
    input  wire logic                          decomp_enable_cfg,
    input  wire logic [1:0]                    internal_rev_cfg,
    input  wire logic [1:0]                    density_blocks_cfg,
    input  wire logic [1:0]                    rev_last_block_cfg,
    input  wire logic [prom_seq_pkg::MEM_AW:0] rev_length_cfg,
    input  wire logic                          mem_wr,
    input  wire logic [1:0]                    mem_wr_block,
    input  wire logic [prom_seq_pkg::MEM_AW-1:0] mem_wr_addr,
    input  wire logic [7:0]                    mem_wr_data,
    output logic [7:0]                         data_out,
    output logic                               data_oe,
    output logic                               source_sync_clock_out,
    output logic                               source_sync_clock_oe,
    output logic                               chain_enable_out_n,
    output logic                               config_pulse_n_out,
    output logic                               config_pulse_n_oe,
    output logic [1:0]                         active_revision
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN  = 4'h2,
        ST_STOP = 4'h4,
        ST_DONE = 4'h8
    } seq_e;

    seq_e                             state_r;
    logic [7:0]                       mem_r [prom_seq_pkg::NUM_BLOCKS][prom_seq_pkg::MEM_BYTES];
    logic [2:0]                       sync_r [5];
    logic                             ext_clk_s;
    logic                             ce_n_s;
    logic                             oe_s;
    logic                             busy_s;
    logic                             cf_s;
    logic                             ext_clk_d_r;
    logic                             cf_d_r;
    logic                             osc_tick;
    logic                             dec_tick;
    logic                             src_tick;
    logic                             src_fall;
    logic                             src_level;
    logic                             osc_lvl_r;
    logic                             tick;
    logic [1:0]                       rev_r;
    logic [1:0]                       blk_r;
    logic [prom_seq_pkg::MEM_AW:0]    addr_r;
    logic                             powered_r;
    logic                             resample;
    logic                             hold;
    logic [1:0]                       sel_rev;
    logic [2:0]                       clk_phase_r;
    logic [7:0]                       cur_byte;
    logic [7:0]                       raw_byte;
    logic [7:0]                       run_cnt_r;
    logic [7:0]                       run_val_r;
    logic                             dec_ready_r;
    logic [3:0]                       cf_low_r;
    logic                             active;

    // Two-flop synchronisers for pins from outside the ref_clk domain
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_sync
            logic pin;
            assign pin = (g == 0) ? ext_clk_in : (g == 1) ? chip_enable_n :
                         (g == 2) ? oe_reset : (g == 3) ? busy : config_pulse_n_in;
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    sync_r[g] <= 3'h0;
                end else begin
                    sync_r[g] <= {sync_r[g][1], pin, 1'b0};
                end
            end
        end
    endgenerate
    assign ext_clk_s = sync_r[0][2];
    assign ce_n_s    = sync_r[1][2];
    assign oe_s      = sync_r[2][2];
    assign busy_s    = sync_r[3][2];
    assign cf_s      = sync_r[4][2];

    // Oscillator at default or slow rate
    clk_divider u_osc (
        .ref_clk     (ref_clk),
        .resetn      (resetn && osc_enable_cfg),
        .half_period (osc_slow_cfg ? 4'(prom_seq_pkg::OSC_DIV_SLOW)
                                   : 4'(prom_seq_pkg::OSC_DIV_FAST)), // RQ1
        .tick_rise   (osc_tick)
    );

    // Edge history of the input clock and config pulse
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ext_clk_d_r <= 1'b0;
            cf_d_r      <= 1'b1;
        end else begin
            ext_clk_d_r <= ext_clk_s;
            cf_d_r      <= cf_s;
        end
    end

    // Oscillator level, toggled every half period
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            osc_lvl_r <= 1'b0;
        end else if (osc_tick) begin
            osc_lvl_r <= ~osc_lvl_r;
        end
    end

    // Source select; decompression further slows the rate
    assign src_tick  = source_sync_clock_out_src_osc_cfg ? (osc_tick && !osc_lvl_r)
                                          : (ext_clk_s && !ext_clk_d_r); // RQ2
    assign src_fall  = source_sync_clock_out_src_osc_cfg ? (osc_tick && osc_lvl_r)
                                          : (!ext_clk_s && ext_clk_d_r);
    assign src_level = source_sync_clock_out_src_osc_cfg ? osc_lvl_r : ext_clk_s;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            clk_phase_r <= 3'h0;
        end else if (src_tick) begin
            clk_phase_r <= clk_phase_r + 3'h1;
        end
    end
    assign dec_tick = src_tick && (clk_phase_r[1:0] == 2'h3); // RQ13
    assign tick     = decomp_enable_cfg ? dec_tick : src_tick;

    // Revision selection and resample on config pulse rise
    assign sel_rev  = external_select_enable ? internal_rev_cfg : revision_select_pins; // RQ18
    assign resample = !powered_r || (!ce_n_s && cf_s && !cf_d_r)
                      || (cf_low_r == 4'h1); // RQ19 RQ20 RQ22
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            powered_r <= 1'b0;
            rev_r     <= prom_seq_pkg::REV_RESET;
        end else if (resample) begin
            powered_r <= 1'b1;
            rev_r     <= sel_rev; // RQ15
        end
    end

    // Boundary-scan config request pulses the config pin low
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cf_low_r <= 4'h0;
        end else if (jtag_config_req && cf_low_r == 4'h0) begin
            cf_low_r <= 4'h8; // RQ22
        end else if (cf_low_r != 4'h0) begin
            cf_low_r <= cf_low_r - 4'h1;
        end
    end

    // Revision to block: a part holding fewer blocks clamps the revision
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            blk_r <= 2'h0;
        end else if (resample) begin
            blk_r <= (sel_rev > density_blocks_cfg) ? density_blocks_cfg : sel_rev; // RQ17
        end
    end

    // Busy only counts in uncompressed parallel mode
    assign hold   = busy_s && parallel_mode && !decomp_enable_cfg; // RQ8 RQ14
    assign active = !ce_n_s && oe_s;

    // Sequencer state
    always_ff @(posedge ref_clk) begin
        if (!resetn || !oe_s || resample) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (active) state_r <= ST_RUN;
                ST_RUN:  if (addr_r >= rev_length_cfg) state_r <= ST_STOP;
                ST_STOP: state_r <= ST_DONE; // RQ6
                ST_DONE: state_r <= ST_DONE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Address counter, reset by oe_reset and revision change
    always_ff @(posedge ref_clk) begin
        if (!resetn || !oe_s || resample) begin
            addr_r <= '0; // RQ24 RQ25
        end else if (state_r == ST_RUN && tick && !hold && dec_ready_r) begin
            addr_r <= addr_r + 1'b1; // RQ23 RQ10
        end
    end

    // Byte store per block; beyond the revision reads all ones
    always_ff @(posedge ref_clk) begin
        if (mem_wr) begin
            mem_r[mem_wr_block][mem_wr_addr] <= mem_wr_data;
        end
    end
    assign raw_byte = (addr_r >= rev_length_cfg || blk_r > rev_last_block_cfg)
                      ? prom_seq_pkg::PAD_BYTE
                      : mem_r[blk_r][addr_r[prom_seq_pkg::MEM_AW-1:0]]; // RQ16

    // Run-length count only: first byte loads the count; output stays the raw stored byte
    always_ff @(posedge ref_clk) begin
        if (!resetn || !oe_s || resample) begin
            run_cnt_r   <= 8'h0;
            run_val_r   <= 8'hff;
            dec_ready_r <= 1'b0;
        end else if (!decomp_enable_cfg) begin
            dec_ready_r <= 1'b1;
        end else if (state_r == ST_RUN && tick && !dec_ready_r) begin
            run_cnt_r   <= raw_byte;
            dec_ready_r <= 1'b1; // RQ11
        end else if (state_r == ST_RUN && tick && run_cnt_r != 8'h0) begin
            run_cnt_r   <= run_cnt_r - 8'h1;
        end
    end
    assign cur_byte = decomp_enable_cfg ? raw_byte : raw_byte;

    // Data changes just after a tick so it is steady at the next rise
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            data_out <= 8'hff;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= active && state_r == ST_RUN;
            if (state_r == ST_RUN && !hold) begin
                data_out <= cur_byte; // RQ3
            end
        end
    end

    // Clock output drive, high impedance when off or not ready
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            source_sync_clock_out <= 1'b1;
            source_sync_clock_oe  <= 1'b0;
        end else begin
            source_sync_clock_oe  <= source_sync_clock_out_enable_cfg && active && state_r == ST_RUN
                                     && dec_ready_r; // RQ4 RQ5 RQ7 RQ13
            // Plain mode follows the source; decompression only rises on every fourth source rise
            if (decomp_enable_cfg) begin
                source_sync_clock_out <= dec_tick ? 1'b1
                                       : (src_fall ? 1'b0 : source_sync_clock_out);
            end else begin
                source_sync_clock_out <= src_level; // RQ9
            end
        end
    end

    // Chain enable released one cycle after clock output stops
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            chain_enable_out_n <= 1'b1;
        end else begin
            chain_enable_out_n <= !(state_r == ST_DONE); // RQ6
        end
    end

    // Config pin and revision report
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            config_pulse_n_out <= 1'b1;
            config_pulse_n_oe  <= 1'b0;
            active_revision    <= prom_seq_pkg::REV_RESET;
        end else begin
            config_pulse_n_out <= 1'b0;
            config_pulse_n_oe  <= cf_low_r != 4'h0; // RQ22
            active_revision    <= rev_r; // RQ21
        end
    end

    // Held address while busy
    chk_busy_holds: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ8
        hold && oe_s && !resample |=> $stable(addr_r))
        else $error("address moved while busy");
    // Chain enable only after clock output released
    chk_ceo_after: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ6
        !chain_enable_out_n |-> !source_sync_clock_oe)
        else $error("chain enable with clock driven");
    // Clock drive needs enables
    chk_clk_gate: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ4
        source_sync_clock_oe |-> $past(active))
        else $error("clock driven while disabled");
    // Decompression ignores busy
    chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ14
        decomp_enable_cfg |-> !hold)
        else $error("busy seen under decompression");
    // Jtag request pulses pin low
    chk_cf_pulse: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ22
        jtag_config_req && cf_low_r == 4'h0 |=> ##1 config_pulse_n_oe)
        else $error("config pulse missing");
    // Revision follows source after resample
    chk_rev_load: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ18
        resample |=> rev_r == $past(sel_rev))
        else $error("revision not loaded");
    // Reset of address by oe_reset
    chk_oe_reset: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ24
        !oe_s |=> addr_r == '0)
        else $error("address not reset");
    // Clock disabled when feature off
    chk_clk_off: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ5
        !source_sync_clock_out_enable_cfg |=> !source_sync_clock_oe)
        else $error("clock driven with feature off");
endmodule

// File: logic/prom_seq_pkg.sv
// Constants shared by the configuration output sequencer
package prom_seq_pkg;
    localparam int          ADDR_W          = 23;           // 8 Mbit per block, bit addresses
    localparam int          BLOCK_W         = 20;           // Byte address bits in one block
    localparam int          DATA_W          = 8;
    localparam logic [1:0]  REV_RESET       = 2'h0;
    localparam int          OSC_DIV_FAST    = 2;            // Ref cycles per oscillator half period
    localparam int          OSC_DIV_SLOW    = 8;
    localparam int          DECOMP_DIV      = 4;            // Source rises per reduced-rate clock rise
    localparam logic [7:0]  PAD_BYTE        = 8'hff;
    localparam int          NUM_BLOCKS      = 4;
    localparam int          MEM_BYTES       = 64;           // Modelled store depth per block
    localparam int          MEM_AW          = 6;
endpackage

// File: testbench/config_prom_output_sequencer_tb.sv
// Self-checking bench for the configuration output sequencer
`timescale 1ns/1ps
module config_prom_output_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        resetn, chip_enable_n, oe_reset, busy, parallel_mode, cf_drv;
    logic        jtag_config_req, external_select_enable, osc_enable_cfg, osc_slow_cfg;
    logic        source_sync_clock_out_enable_cfg, source_sync_clock_out_src_osc_cfg, mem_wr;
    logic [1:0]  revision_select_pins, internal_rev_cfg, rev_last_block_cfg, mem_wr_block;
    logic [prom_seq_pkg::MEM_AW:0]   rev_length_cfg;
    logic [prom_seq_pkg::MEM_AW-1:0] mem_wr_addr;
    logic [7:0]  mem_wr_data, data_out, cap_data;
    logic        data_oe, source_sync_clock_out, source_sync_clock_oe, chain_enable_out_n;
    logic        config_pulse_n_out, config_pulse_n_oe, ext_clk_in;
    logic [1:0]  active_revision;
    logic [7:0]  store [4][8];
    logic [7:0]  exp_q [$];
    logic [31:0] rng = 32'h3ab0;
    int          bad_count = 0, comparisons = 0, sclk_edges = 0, e0, hi;
    // Pull-up on the shared config pin; design only ever pulls it low
    wire         cf_pin = cf_drv & ~(config_pulse_n_oe & ~config_pulse_n_out);
    // Pulled-up level of the clock output pin while released
    wire         sclk_pin = source_sync_clock_oe ? source_sync_clock_out : 1'b1;

    always #12.5 ref_clk = ~ref_clk;
    always @(source_sync_clock_out) sclk_edges++;

    config_prom_output_sequencer config_prom_output_sequencer_i (
        .ref_clk, .resetn, .ext_clk_in, .chip_enable_n, .oe_reset, .busy, .parallel_mode,
        .config_pulse_n_in(cf_pin), .jtag_config_req, .revision_select_pins,
        .external_select_enable, .osc_enable_cfg, .osc_slow_cfg, .source_sync_clock_out_enable_cfg,
        .source_sync_clock_out_src_osc_cfg, .decomp_enable_cfg(1'b0), .internal_rev_cfg,
        .density_blocks_cfg(2'h3), .rev_last_block_cfg, .rev_length_cfg, .mem_wr,
        .mem_wr_block, .mem_wr_addr, .mem_wr_data, .data_out, .data_oe,
        .source_sync_clock_out, .source_sync_clock_oe, .chain_enable_out_n,
        .config_pulse_n_out, .config_pulse_n_oe, .active_revision);

    config_target_model config_target_model_i (
        .data_in(data_out), .link_clk(ext_clk_in), .cap_data(cap_data));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Bytes past the revision length read as padding
    function automatic logic [7:0] exp_byte(input logic [1:0] r, input int a);
        return (a < int'(rev_length_cfg)) ? store[r][a] : 8'hff;
    endfunction

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %0d want %0d", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Note expected bytes, then let the target clock them out
    task automatic stream(input logic [1:0] r, input int a, input int n, input bit hold);
        for (int i = 0; i < n; i++) exp_q.push_back(exp_byte(r, hold ? a : a + i));
        config_target_model_i.send_clocks(n);
        cyc(6);
        chk_cnt(exp_q.size(), 0, "bytes left unclocked");
    endtask

    // Oldest note is compared with each captured byte
    always @(posedge ext_clk_in) begin
        if (exp_q.size() == 0) begin
            bad_count++;
            $display("[FAIL] %0t unexpected byte %h", $time, cap_data);
        end else begin
            chk_val(cap_data, exp_q.pop_front(), "stream byte");
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard well beyond the expected run length
    initial begin
        cyc(20000);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        {resetn, oe_reset, busy, jtag_config_req, mem_wr, osc_enable_cfg} = '0;
        {osc_slow_cfg, source_sync_clock_out_src_osc_cfg, external_select_enable} = '0;
        {chip_enable_n, parallel_mode, cf_drv, source_sync_clock_out_enable_cfg} = '1;
        revision_select_pins = 2'h2;
        internal_rev_cfg = 2'h3;
        rev_last_block_cfg = 2'h2;
        rev_length_cfg = 7'h06;
        {mem_wr_block, mem_wr_addr, mem_wr_data} = '0;
        cyc(8);
        resetn <= 1'b1;
        // Random store contents, eight bytes in each block
        for (int b = 0; b < 4; b++) begin
            for (int a = 0; a < 8; a++) begin
                rng = xorshift(rng);
                store[b][a] = rng[7:0];
                mem_wr <= 1'b1;
                mem_wr_block <= 2'(b);
                mem_wr_addr <= 6'(a);
                mem_wr_data <= rng[7:0];
                cyc(1);
            end
        end
        mem_wr <= 1'b0;
        cyc(2);
        chk_val({6'h00, active_revision}, 8'h02, "power-up revision");
        chk_val({7'h00, source_sync_clock_oe}, 8'h00, "clock out idle");
        chk_val({7'h00, sclk_pin}, 8'h01, "released clock pin level");
        oe_reset <= 1'b1;
        chip_enable_n <= 1'b0;
        cyc(6);
        stream(2'h2, 0, 4, 1'b0);
        chk_val({7'h00, source_sync_clock_oe}, 8'h01, "clock out driven");
        busy <= 1'b1;
        cyc(6);
        e0 = sclk_edges;
        stream(2'h2, 4, 3, 1'b1);
        chk_cnt(sclk_edges - e0, 6, "clock edges while busy");
        busy <= 1'b0;
        cyc(6);
        stream(2'h2, 4, 3, 1'b0);
        // Serial mode ignores busy; oe_reset restarts the address
        parallel_mode <= 1'b0;
        busy <= 1'b1;
        oe_reset <= 1'b0;
        cyc(6);
        oe_reset <= 1'b1;
        cyc(6);
        stream(2'h2, 0, 3, 1'b0);
        busy <= 1'b0;
        revision_select_pins <= 2'h1;
        rev_last_block_cfg <= 2'h1;
        cf_drv <= 1'b0;
        cyc(4);
        cf_drv <= 1'b1;
        cyc(8);
        chk_val({6'h00, active_revision}, 8'h01, "revision after cf");
        stream(2'h1, 0, 3, 1'b0);
        // Boundary-scan config pulse with internal selection bits
        external_select_enable <= 1'b1;
        rev_last_block_cfg <= 2'h3;
        jtag_config_req <= 1'b1;
        cyc(1);
        jtag_config_req <= 1'b0;
        hi = 0;
        repeat (20) begin
            cyc(1);
            if (config_pulse_n_oe === 1'b1 && cf_pin === 1'b0) hi++;
        end
        chk_cnt(hi, 8, "config pin low cycles");
        cyc(8);
        chk_val({6'h00, active_revision}, 8'h03, "internal revision");
        chip_enable_n <= 1'b1;
        cyc(6);
        chk_val({7'h00, source_sync_clock_oe}, 8'h00, "clock out with ce high");
        // Oscillator as clock source, both rates
        source_sync_clock_out_src_osc_cfg <= 1'b1;
        osc_enable_cfg <= 1'b1;
        chip_enable_n <= 1'b0;
        cyc(16);
        e0 = sclk_edges;
        cyc(40);
        chk_cnt(sclk_edges - e0, 40 / prom_seq_pkg::OSC_DIV_FAST, "fast rate");
        osc_slow_cfg <= 1'b1;
        cyc(32);
        e0 = sclk_edges;
        cyc(64);
        chk_cnt(sclk_edges - e0, 64 / prom_seq_pkg::OSC_DIV_SLOW, "slow rate");
        osc_slow_cfg <= 1'b0;
        cyc(600);
        chk_val({7'h00, source_sync_clock_oe}, 8'h00, "clock released at end");
        chk_val({7'h00, chain_enable_out_n}, 8'h00, "chain enable at end");
        finish_test();
    end
endmodule

// File: testbench/config_target_model.sv
// Behavioural target configuration logic that clocks and captures bytes
`timescale 1ns/1ps
module config_target_model (
    input  wire logic [7:0] data_in,
    output logic            link_clk,
    output logic [7:0]      cap_data
);
    // Uncompressed streams only; compressed ones need a slave on clock out
    // Link clock stands low between frames
    initial begin
        link_clk = 1'b0;
        cap_data = 8'h00;
    end

    // One captured byte per rising link edge, taken just before the edge
    task automatic send_clocks(input int n);
        #7;
        for (int i = 0; i < n; i++) begin
            #100;
            cap_data = data_in;
            link_clk = 1'b1;
            #100;
            link_clk = 1'b0;
        end
    endtask
endmodule
